// ### common/lpwc_pkg.sv
// lpwc_pkg: register map, field positions, reset values and types for the low-power mode and wake controller.
// assumes a 32-bit classic wishbone slave with word-aligned registers at byte address four times the index.
package lpwc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] LPWC_IDX_PORT0_WAKE = 8'h9b;
	localparam logic [7:0] LPWC_IDX_PORT1_WAKE = 8'h9c;
	localparam logic [7:0] LPWC_IDX_PORT0_CHG = 8'h9d;
	localparam logic [7:0] LPWC_IDX_PORT1_CHG = 8'h9e;
	localparam logic [7:0] LPWC_IDX_OSC_MODE = 8'ha0;
	localparam logic [7:0] LPWC_IDX_IRQ_REQ = 8'ha1;
	localparam logic [7:0] LPWC_IDX_IRQ_EN = 8'ha2;
	localparam int LPWC_ADDR_W = 10;

	// oscillator_mode_register fields
	localparam int LPWC_OSC_SLEEP_BIT = 0;
	localparam int LPWC_OSC_IDLE_BIT = 1;
	localparam int LPWC_OSC_SLOW_BIT = 2;
	localparam int LPWC_OSC_RC_SRC_BIT = 3;

	// interrupt request fields (write one to clear)
	localparam int LPWC_IRQ_WAKE_BIT = 0;
	localparam int LPWC_IRQ_FLAG_BIT = 1;
	localparam int LPWC_IRQ_P0_BIT = 2;
	localparam int LPWC_IRQ_P1_BIT = 3;
	localparam int LPWC_IRQ_TMR_BIT = 4;

	// interrupt enable fields
	localparam int LPWC_IEN_WAKE_BIT = 0;

	// reset values and implemented-bit masks
	localparam logic [7:0] LPWC_RST_BYTE = 8'h00;
	localparam logic [7:0] LPWC_PORT0_MASK = 8'hff;
	localparam logic [7:0] LPWC_PORT1_MASK = 8'hbf;
	localparam logic [3:0] LPWC_OSC_MASK = 4'hf;
	localparam logic [4:0] LPWC_IRQ_MASK = 5'h1f;

	// oscillator settling counts, in oscillator clocks
	localparam logic [11:0] LPWC_SETTLE_EXT_CLOCKS = 12'h800;
	localparam logic [11:0] LPWC_SETTLE_RC_CLOCKS = 12'h040;

	// wake interrupt vector
	localparam logic [15:0] LPWC_WAKE_VECTOR = 16'h0008;

	typedef enum logic [2:0] {
		LPWC_NORMAL,
		LPWC_SLOW,
		LPWC_IDLE,
		LPWC_SLEEP,
		LPWC_SETTLE
	} lpwc_mode_type;

	typedef struct packed {
		logic [7:0] port0;
		logic [7:0] port1;
	} lpwc_pins_type;

	typedef struct packed {
		logic cpu_halt;
		logic sys_osc_run;
		logic slow_clk_sel;
		logic periph_run;
	} lpwc_power_type;

endpackage

// ### rtl/lpwc_edge.sv
// lpwc_edge: per-pin level-change detector for one 8-bit port.
// assumes pins are synchronous to clk; the first sample after reset only primes the history.
`timescale 1ns/1ns
module lpwc_edge
	import lpwc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// pins and result
	input wire logic [7:0] pins,
	output logic [7:0] change
);
	logic [7:0] prev_reg;
	logic [7:0] prev_next;
	logic primed_reg;
	logic primed_next;

	always_comb
	begin
		prev_next = pins;
		primed_next = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev_reg <= LPWC_RST_BYTE;
			primed_reg <= 1'b0;
		end
		else
		begin
			prev_reg <= prev_next;
			primed_reg <= primed_next;
		end
	end

	// rising or falling both count
	assign change = primed_reg ? (pins ^ prev_reg) : LPWC_RST_BYTE; // RQ12

endmodule // lpwc_edge

// ### rtl/lpwc_ctrl.sv
// lpwc_ctrl: idle and sleep mode control, pin and timer wake, wake flags and oscillator settling wait.
// assumes a classic wishbone master, pins synchronous to clk, and a one-cycle basic timer overflow pulse.
// Overview of operation
// (RQ1) writing one to the idle request bit enters idle mode and halts the cpu
// (RQ2) leaving idle clears the idle request bit and sets the wake flag
// (RQ3) idle keeps the system oscillator running so its timers keep counting
// (RQ4) idle wakes only on an enabled port 1 change or timer overflow
// (RQ5) idle wake resumes the mode active before entry, normal or slow
// (RQ6) sleep wakes only on an enabled pin change and resumes in normal mode
// (RQ7) wake by an external interrupt source sets its request flag, not the wake flag
// (RQ8) system-clocked peripherals keep running in idle but never cause a wake
// (RQ9) a wake raises the wake request; with its enable set, vector to address 8
// (RQ10) after sleep wake, wait 2048 external or 64 internal rc clocks
// (RQ11) idle wake inserts no settling delay
// (RQ12) rising or falling edge on a wake-enabled pin both trigger a wake
// (RQ13) port 0 wake enable: eight read-write bits, one per pin, reset zero
// (RQ14) port 1 wake enable: bits 7 and 5..0, bit 6 absent, reset zero
// (RQ15) port 0 change interrupt enable: eight read-write bits, reset zero
// (RQ16) port 1 change interrupt enable: bits 7 and 5..0, bit 6 absent
// (RQ17) wake flag stays set until software clears it
// (RQ18) of the timers, only the basic timer overflow wakes from idle
// (RQ19) writing one to the sleep request bit stops all oscillators
// (RQ20) sleep wake clears the sleep request bit
// (RQ21) simultaneous pin change and timer overflow give one wake, all flags set
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
module lpwc_ctrl
	import lpwc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [LPWC_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// port pins and wake-capable timer
	input wire lpwc_pkg::lpwc_pins_type pins,
	input wire logic basic_timer_ovf,
	// power control and wake vector
	output lpwc_pkg::lpwc_power_type power,
	output logic wake_vector_req,
	output logic [15:0] wake_vector_addr
);
	import lpwc_pkg::*;

	function automatic logic [7:0] addr_index(input logic [LPWC_ADDR_W-1:0] adr);
		addr_index = adr[LPWC_ADDR_W-1:2];
	endfunction

	// settling length in system clocks, standing in for oscillator clocks
	function automatic logic [11:0] settle_count(input logic rc_src);
		if (rc_src)
			settle_count = LPWC_SETTLE_RC_CLOCKS;
		else
			settle_count = LPWC_SETTLE_EXT_CLOCKS;
	endfunction

	// bit 6 of port 1 has no pin, so it may never enable or report anything
	function automatic logic [7:0] port1_only(input logic [7:0] bits);
		port1_only = bits & LPWC_PORT1_MASK;
	endfunction

	function automatic logic halted_mode(input lpwc_mode_type m);
		halted_mode = (m == LPWC_IDLE) || (m == LPWC_SLEEP) || (m == LPWC_SETTLE);
	endfunction

	// bus side
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic bus_req;
	logic bus_wr;
	logic [7:0] idx;
	logic [7:0] wbyte;

	// registers
	logic [7:0] p0_wake_reg;
	logic [7:0] p0_wake_next;
	logic [7:0] p1_wake_reg;
	logic [7:0] p1_wake_next;
	logic [7:0] p0_chg_reg;
	logic [7:0] p0_chg_next;
	logic [7:0] p1_chg_reg;
	logic [7:0] p1_chg_next;
	logic [3:0] osc_reg;
	logic [3:0] osc_next;
	logic [4:0] irq_reg;
	logic [4:0] irq_next;
	logic ien_reg;
	logic ien_next;

	// mode machine
	lpwc_mode_type mode_reg;
	lpwc_mode_type mode_next;
	logic [11:0] settle_reg;
	logic [11:0] settle_next;

	// events
	logic [7:0] p0_change;
	logic [7:0] p1_change;
	logic p0_wake_hit;
	logic p1_wake_hit;
	logic p0_ext_hit;
	logic p1_ext_hit;
	logic p0_irq_set;
	logic p1_irq_set;
	logic idle_wake;
	logic sleep_wake;
	logic idle_plain;
	logic sleep_plain;
	logic wake_plain;

	// one detector per port; the missing port 1 pin is masked where the changes are used
	lpwc_edge u_edge_p0 (
		.clk(clk),
		.arst_n(arst_n),
		.pins(pins.port0),
		.change(p0_change)
	);

	lpwc_edge u_edge_p1 (
		.clk(clk),
		.arst_n(arst_n),
		.pins(pins.port1),
		.change(p1_change)
	);

	// bus decode; writes land on the edge at which ack is seen
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign bus_wr = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
	assign idx = addr_index(wb_adr_i);
	assign wbyte = wb_dat_i[7:0];

	// one wait state; a held request is answered every other cycle
	// read data is captured with the request so it stands through the ack cycle
	always_comb
	begin
		ack_next = bus_req && !ack_reg;
		rdata_next = 32'h0000_0000;
		case (idx)
			LPWC_IDX_PORT0_WAKE: rdata_next[7:0] = p0_wake_reg;
			LPWC_IDX_PORT1_WAKE: rdata_next[7:0] = p1_wake_reg;
			LPWC_IDX_PORT0_CHG: rdata_next[7:0] = p0_chg_reg;
			LPWC_IDX_PORT1_CHG: rdata_next[7:0] = p1_chg_reg;
			LPWC_IDX_OSC_MODE: rdata_next[3:0] = osc_reg;
			LPWC_IDX_IRQ_REQ: rdata_next[4:0] = irq_reg;
			LPWC_IDX_IRQ_EN: rdata_next[LPWC_IEN_WAKE_BIT] = ien_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// wake decode; peripheral overflows other than the basic timer are not inputs here
	assign p0_wake_hit = |(p0_change & p0_wake_reg);
	assign p1_wake_hit = |(port1_only(p1_change & p1_wake_reg)); // RQ12
	assign p0_ext_hit = |(p0_change & p0_wake_reg & p0_chg_reg);
	assign p1_ext_hit = |(port1_only(p1_change & p1_wake_reg & p1_chg_reg));
	assign idle_wake = (mode_reg == LPWC_IDLE) && (p1_wake_hit || basic_timer_ovf); // RQ4 RQ18 RQ8
	assign sleep_wake = (mode_reg == LPWC_SLEEP) && (p0_wake_hit || p1_wake_hit); // RQ6
	// a wake caused by a pin that is also an external interrupt source leaves the wake flag alone
	assign idle_plain = idle_wake && (basic_timer_ovf || (p1_wake_hit && !p1_ext_hit));
	assign sleep_plain = sleep_wake && ((p0_wake_hit && !p0_ext_hit) || (p1_wake_hit && !p1_ext_hit));
	assign wake_plain = idle_plain || sleep_plain; // RQ7 RQ21
	assign p0_irq_set = |(p0_change & p0_chg_reg);
	assign p1_irq_set = |(port1_only(p1_change & p1_chg_reg));

	// enable registers
	always_comb
	begin
		p0_wake_next = p0_wake_reg;
		p1_wake_next = p1_wake_reg;
		p0_chg_next = p0_chg_reg;
		p1_chg_next = p1_chg_reg;
		ien_next = ien_reg;
		if (bus_wr)
		begin
			case (idx)
				LPWC_IDX_PORT0_WAKE: p0_wake_next = wbyte & LPWC_PORT0_MASK; // RQ13
				LPWC_IDX_PORT1_WAKE: p1_wake_next = wbyte & LPWC_PORT1_MASK; // RQ14
				LPWC_IDX_PORT0_CHG: p0_chg_next = wbyte & LPWC_PORT0_MASK; // RQ15
				LPWC_IDX_PORT1_CHG: p1_chg_next = wbyte & LPWC_PORT1_MASK; // RQ16
				LPWC_IDX_IRQ_EN: ien_next = wbyte[LPWC_IEN_WAKE_BIT];
				default: ien_next = ien_reg;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			p0_wake_reg <= LPWC_RST_BYTE; // RQ13
			p1_wake_reg <= LPWC_RST_BYTE; // RQ14
			p0_chg_reg <= LPWC_RST_BYTE; // RQ15
			p1_chg_reg <= LPWC_RST_BYTE; // RQ16
			ien_reg <= 1'b0;
		end
		else
		begin
			p0_wake_reg <= p0_wake_next;
			p1_wake_reg <= p1_wake_next;
			p0_chg_reg <= p0_chg_next;
			p1_chg_reg <= p1_chg_next;
			ien_reg <= ien_next;
		end
	end

	// request flags: write one clears, a same-cycle set wins
	// port flags follow their change enables in every mode, since interrupts stay live
	always_comb
	begin
		irq_next = irq_reg;
		if (bus_wr && idx == LPWC_IDX_IRQ_REQ)
			irq_next = irq_reg & ~(wbyte[4:0] & LPWC_IRQ_MASK); // RQ17
		if (wake_plain)
		begin
			irq_next[LPWC_IRQ_WAKE_BIT] = 1'b1; // RQ9
			irq_next[LPWC_IRQ_FLAG_BIT] = 1'b1; // RQ2
		end
		if (p0_irq_set)
			irq_next[LPWC_IRQ_P0_BIT] = 1'b1; // RQ7
		if (p1_irq_set)
			irq_next[LPWC_IRQ_P1_BIT] = 1'b1; // RQ7 RQ21
		if (basic_timer_ovf)
			irq_next[LPWC_IRQ_TMR_BIT] = 1'b1; // RQ21
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_reg <= 5'h00;
		else
			irq_reg <= irq_next;
	end

	// mode machine and oscillator_mode_register
	always_comb
	begin
		mode_next = mode_reg;
		osc_next = osc_reg;
		settle_next = settle_reg;
		if (bus_wr && idx == LPWC_IDX_OSC_MODE)
			osc_next = wbyte[3:0] & LPWC_OSC_MASK;
		case (mode_reg)
			LPWC_NORMAL, LPWC_SLOW:
			begin
				// sleep takes priority when both request bits are written together
				if (osc_reg[LPWC_OSC_SLEEP_BIT])
					mode_next = LPWC_SLEEP; // RQ19
				else if (osc_reg[LPWC_OSC_IDLE_BIT])
					mode_next = LPWC_IDLE; // RQ1
				else if (osc_reg[LPWC_OSC_SLOW_BIT])
					mode_next = LPWC_SLOW;
				else
					mode_next = LPWC_NORMAL;
			end
			LPWC_IDLE:
			begin
				if (idle_wake)
				begin
					// the hardware clear wins over a software write in the same cycle
					osc_next[LPWC_OSC_IDLE_BIT] = 1'b0; // RQ2
					// no settling: the system clock never stopped
					mode_next = osc_reg[LPWC_OSC_SLOW_BIT] ? LPWC_SLOW : LPWC_NORMAL; // RQ5 RQ11
				end
			end
			LPWC_SLEEP:
			begin
				if (sleep_wake)
				begin
					osc_next[LPWC_OSC_SLEEP_BIT] = 1'b0; // RQ20
					osc_next[LPWC_OSC_IDLE_BIT] = 1'b0;
					osc_next[LPWC_OSC_SLOW_BIT] = 1'b0; // RQ6
					settle_next = settle_count(osc_reg[LPWC_OSC_RC_SRC_BIT]); // RQ10
					mode_next = LPWC_SETTLE;
				end
			end
			LPWC_SETTLE:
			begin
				// pin events here are not wakes; the cpu stays held until the count ends
				settle_next = settle_reg - 12'h001;
				if (settle_reg == 12'h001)
					mode_next = LPWC_NORMAL; // RQ10 RQ6
			end
			default:
			begin
				mode_next = LPWC_NORMAL;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_reg <= LPWC_NORMAL;
			osc_reg <= 4'h0;
			settle_reg <= 12'h000;
		end
		else
		begin
			mode_reg <= mode_next;
			osc_reg <= osc_next;
			settle_reg <= settle_next;
		end
	end

	// power outputs
	always_comb
	begin
		power.cpu_halt = halted_mode(mode_reg); // RQ1
		power.sys_osc_run = (mode_reg != LPWC_SLEEP); // RQ3 RQ19
		power.slow_clk_sel = (mode_reg == LPWC_SLOW) || ((mode_reg == LPWC_IDLE) && osc_reg[LPWC_OSC_SLOW_BIT]);
		power.periph_run = (mode_reg != LPWC_SLEEP) && (mode_reg != LPWC_SETTLE); // RQ8
	end

	// vector request holds until software clears the wake request
	assign wake_vector_req = irq_reg[LPWC_IRQ_WAKE_BIT] && ien_reg && !power.cpu_halt; // RQ9
	assign wake_vector_addr = LPWC_WAKE_VECTOR; // RQ9

endmodule // lpwc_ctrl

// ### verif/lpwc_ctrl_assertions.sv
// lpwc_ctrl_assertions: port-level checks of the wake controller.
// assumes it is bound to lpwc_ctrl and reset through arst_n.
`timescale 1ns/1ns
module lpwc_ctrl_assertions
	import lpwc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [LPWC_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins and power
	input wire lpwc_pkg::lpwc_pins_type pins,
	input wire logic basic_timer_ovf,
	input wire lpwc_pkg::lpwc_power_type power,
	input wire logic wake_vector_req,
	input wire logic [15:0] wake_vector_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic idle, settle, settle_reg, settle_next;
	logic [11:0] cnt_reg, cnt_next;
	assign idle = power.cpu_halt & power.sys_osc_run & power.periph_run;
	assign settle = power.cpu_halt & power.sys_osc_run & !power.periph_run;
	// counts settle cycles so the length can be checked on exit
	always_comb
	begin
		cnt_next = settle ? cnt_reg + 12'h001 : 12'h000;
		settle_next = settle;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg <= 12'h000;
			settle_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			settle_reg <= settle_next;
		end
	end
	sequence s_idle_tick;
		idle && basic_timer_ovf && !wb_cyc_i;
	endsequence
	sequence s_idle_quiet;
		idle && !basic_timer_ovf && $stable(pins.port1) && !wb_cyc_i;
	endsequence
	sequence s_idle_exit;
		idle ##1 !power.cpu_halt;
	endsequence
	a_idle_timer_wake: assert property (s_idle_tick |=> !power.cpu_halt)
		else $error("timer overflow did not end idle");
	a_idle_stays: assert property (s_idle_quiet |=> power.cpu_halt)
		else $error("idle left without a wake source");
	a_idle_resume: assert property (s_idle_exit |-> $stable(power.slow_clk_sel))
		else $error("idle wake changed the clock mode");
	a_vector_gated: assert property (wake_vector_req |-> !power.cpu_halt && wake_vector_addr == 16'h0008)
		else $error("wake vector wrong or raised while halted");
	a_idle_clk_runs: assert property (power.cpu_halt && power.periph_run |-> power.sys_osc_run)
		else $error("oscillator stopped in idle");
	a_sleep_stops: assert property (!power.sys_osc_run |-> power.cpu_halt && !power.periph_run)
		else $error("sleep without halt");
	a_sleep_settle: assert property (!power.sys_osc_run ##1 power.sys_osc_run |-> settle)
		else $error("sleep wake skipped settling");
	a_settle_len: assert property (settle_reg && !settle |-> cnt_reg inside {[64:65], [2048:2049]})
		else $error("settling length wrong");
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
endmodule // lpwc_ctrl_assertions

// ### verif/lpwc_pin_model.sv
// lpwc_pin_model: port pins and basic timer facing the controller.
// assumes the bench asks for flips and ticks one cycle wide.
`timescale 1ns/1ns
module lpwc_pin_model
	import lpwc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// requests from the bench
	input wire logic [7:0] flip0,
	input wire logic [7:0] flip1,
	input wire logic tick,
	// toward the controller
	output lpwc_pkg::lpwc_pins_type pins,
	output logic basic_timer_ovf
);
	lpwc_pins_type pins_reg, pins_next;
	logic ovf_reg, ovf_next;
	always_comb
	begin
		pins_next = pins_reg ^ {flip0, flip1};
		ovf_next = tick;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pins_reg <= 16'h5a3c;
			ovf_reg <= 1'b0;
		end
		else
		begin
			pins_reg <= pins_next;
			ovf_reg <= ovf_next;
		end
	end
	assign pins = pins_reg;
	assign basic_timer_ovf = ovf_reg;
endmodule // lpwc_pin_model

// ### verif/test_low_power_mode_wakeup_control.sv
// test_low_power_mode_wakeup_control: random and corner tests of lpwc_ctrl.
// assumes lpwc_pin_model drives the pins and the timer pulse.
`timescale 1ns/1ns
module test_low_power_mode_wakeup_control;
	import lpwc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rq = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] di = 32'h0;
	logic [31:0] dout;
	logic ack, tk = 1'b0, vreq;
	logic [7:0] t0 = 8'h00, t1 = 8'h00, q, r;
	logic [15:0] vaddr;
	lpwc_pins_type pins;
	logic ovf;
	lpwc_power_type power;
	int fails = 0, n_tests = 0, cnt, seed = 32'hf1c0beb1;
	logic [7:0] ri [4] = '{8'h9b, 8'h9c, 8'h9d, 8'h9e};
	always #5 clk = ~clk;
	lpwc_pin_model pm (.clk(clk), .arst_n(arst_n), .flip0(t0), .flip1(t1), .tick(tk), .pins(pins),
		.basic_timer_ovf(ovf));
	lpwc_ctrl uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(rq), .wb_stb_i(rq), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .pins(pins), .basic_timer_ovf(ovf),
		.power(power), .wake_vector_req(vreq), .wake_vector_addr(vaddr));
	function automatic logic [7:0] mk(input logic [7:0] i);
		return (i == 8'h9b || i == 8'h9d) ? 8'hff : 8'hbf;
	endfunction
	task test_done;
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] i, d, input logic s);
		@(posedge clk);
		rq <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		di <= {24'h0, d};
		sel <= {3'h0, s};
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		q = dout[7:0];
		rq <= 1'b0;
	endtask
	task wr(input logic [7:0] i, d);
		bus(1'b1, i, d, 1'b1);
	endtask
	task rd(input logic [7:0] i, m, e);
		bus(1'b0, i, 8'h00, 1'b1);
		chk(q & m, e);
	endtask
	task poke(input logic [7:0] a, b, input logic t);
		@(posedge clk);
		t0 <= a;
		t1 <= b;
		tk <= t;
		@(posedge clk);
		t0 <= 8'h00;
		t1 <= 8'h00;
		tk <= 1'b0;
	endtask
	task wh(input logic v);
		cnt = 0;
		while (power.cpu_halt !== v && cnt < 3000)
		begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 3000)
			fails++;
	endtask
	initial
	begin
		#500000;
		fails++;
		test_done;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		foreach (ri[k]) rd(ri[k], 8'hff, 8'h00);
		repeat (3)
		foreach (ri[k])
		begin
			r = 8'($random(seed));
			wr(ri[k], r);
			rd(ri[k], 8'hff, r & mk(ri[k]));
		end
		bus(1'b1, 8'h9e, ~r, 1'b0);
		rd(8'h9e, 8'hff, r & mk(8'h9e));
		wr(8'h90, 8'hff);
		rd(8'h90, 8'hff, 8'h00);
		foreach (ri[k]) wr(ri[k], 8'h00);
		// idle from normal, port0 must not wake, port1 pin does
		wr(8'h9b, 8'hff);
		wr(8'h9c, 8'h01);
		wr(8'ha0, 8'h02);
		wh(1'b1);
		poke(8'h01, 8'h02, 1'b0);
		repeat (5) @(negedge clk);
		chk(power.cpu_halt, 1'b1);
		poke(8'h00, 8'h01, 1'b0);
		wh(1'b0);
		chk(cnt < 5, 1'b1);
		rd(8'ha0, 8'hff, 8'h00);
		rd(8'ha1, 8'h13, 8'h03);
		chk(vreq, 1'b0);
		wr(8'ha2, 8'h01);
		@(negedge clk);
		chk(vreq, 1'b1);
		chk(vaddr, 16'h0008);
		wr(8'ha1, 8'h1f);
		rd(8'ha1, 8'h1f, 8'h00);
		// idle from slow, timer wake
		wr(8'ha0, 8'h04);
		wr(8'ha0, 8'h06);
		wh(1'b1);
		poke(8'h00, 8'h00, 1'b1);
		wh(1'b0);
		chk(power.slow_clk_sel, 1'b1);
		rd(8'ha1, 8'h13, 8'h13);
		wr(8'ha0, 8'h00);
		wr(8'ha1, 8'h1f);
		// pin change and timer together
		wr(8'ha0, 8'h02);
		wh(1'b1);
		poke(8'h00, 8'h01, 1'b1);
		wh(1'b0);
		rd(8'ha1, 8'h13, 8'h13);
		wr(8'ha1, 8'h1f);
		// wake pin that is also an interrupt source
		wr(8'h9e, 8'h01);
		wr(8'ha0, 8'h02);
		wh(1'b1);
		poke(8'h00, 8'h01, 1'b0);
		wh(1'b0);
		rd(8'ha1, 8'h0b, 8'h08);
		wr(8'ha1, 8'h1f);
		// sleep from slow with rc settling, then sleep from normal with external settling
		wr(8'ha0, 8'h04);
		wr(8'ha0, 8'h0d);
		wh(1'b1);
		chk(power.sys_osc_run, 1'b0);
		poke(8'h00, 8'h00, 1'b1);
		repeat (5) @(negedge clk);
		chk(power.cpu_halt, 1'b1);
		poke(8'h80, 8'h00, 1'b0);
		wh(1'b0);
		chk(cnt inside {[64:68]}, 1'b1);
		chk(power.slow_clk_sel, 1'b0);
		rd(8'ha0, 8'h07, 8'h00);
		wr(8'ha0, 8'h01);
		wh(1'b1);
		poke(8'h80, 8'h00, 1'b0);
		wh(1'b0);
		chk(cnt inside {[2048:2052]}, 1'b1);
		test_done;
	end
endmodule // test_low_power_mode_wakeup_control
bind lpwc_ctrl lpwc_ctrl_assertions u_chk (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pins(pins), .basic_timer_ovf(basic_timer_ovf), .power(power),
	.wake_vector_req(wake_vector_req), .wake_vector_addr(wake_vector_addr));
